// ### common/eeprom_pin_mux_pkg.sv
// constants and carrier types for the eeprom pin multiplexer
// assumes one 20 MHz clock and an asynchronous active-low reset
package eeprom_pin_mux_pkg;

  // data pin function codes
  typedef enum logic [1:0] {
    data_fn_eeprom  = 2'h0,
    data_fn_general = 2'h1,
    data_fn_tx_en   = 2'h2,
    data_fn_tx_clk  = 2'h3
  } data_fn_type;

  // clock pin function codes
  typedef enum logic [1:0] {
    clk_fn_eeprom  = 2'h0,
    clk_fn_general = 2'h1,
    clk_fn_rx_dv   = 2'h2,
    clk_fn_rx_clk  = 2'h3
  } clk_fn_type;

  // write-gate states, one-hot
  typedef enum logic [1:0] {
    gate_locked = 2'h1,
    gate_open   = 2'h2
  } gate_state_type;

  // software configuration carried as one word
  typedef struct packed {
    data_fn_type data_fn;
    clk_fn_type  clk_fn;
    logic        general_three;
    logic        general_four;
  } pin_cfg_type;

  localparam pin_cfg_type cfg_reset_value = '{data_fn_eeprom, clk_fn_eeprom, 1'b0, 1'b0};
  localparam logic        strap_reset_value = 1'b0;
  localparam logic        width_32_level    = 1'b1;
  localparam int          por_cycles        = 16;
  localparam logic [4:0]  por_count_last    = 5'h10;

endpackage : eeprom_pin_mux_pkg

// ### hw/eeprom_pin_mux_strap.sv
// pin multiplexer for the serial eeprom data and clock pins, with bus-width strap
// assumes synchronous pin inputs on sys_clk; the pad combines the three pin signals
// assumes the internal eeprom controller and mii signals arrive on sys_clk
// a pad pull-up holds the external reset pin high when it is left loose
`timescale 1ns/1ps
`default_nettype none

// one-of-four function selector shared by both pins
// one selector per pin keeps the two muxes identical
module pin_fn_select
  import eeprom_pin_mux_pkg::*;
#(
  parameter int unsigned src_count = 4
) (
  input  wire logic [1:0]           sel,
  input  wire logic [src_count-1:0] sources,
  output logic                      picked
);

  // source index equals the function code
  assign picked = sources[sel];

endmodule : pin_fn_select

module eeprom_pin_mux_strap
  import eeprom_pin_mux_pkg::*;
(
  // clock and resets
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        external_reset_n,
  input  wire logic        external_reset_present,

  // host events
  input  wire logic        wake_event,
  input  wire logic        host_read,
  input  wire logic        host_write,

  // configuration word
  input  wire pin_cfg_type cfg_wdata,
  output logic             host_write_taken,
  output pin_cfg_type      cfg_ff,
  output logic             write_enabled,

  // internal eeprom controller
  input  wire logic        eeprom_select,
  input  wire logic        eeprom_clock,
  input  wire logic        eeprom_data_out,
  input  wire logic        eeprom_data_drive,
  output logic             eeprom_data_in,

  // internal mii signals to mirror
  input  wire logic        tx_en,
  input  wire logic        tx_clk,
  input  wire logic        rx_dv,
  input  wire logic        rx_clk,

  // pads, strap and reset status
  input  wire logic        eeprom_serial_data_pin_i,
  output logic             eeprom_serial_data_pin_o,
  output logic             eeprom_serial_data_pin_oe_n,
  output logic             eeprom_serial_clock_pin,
  output logic             eeprom_select_n,
  output logic             bus_width_strap,
  output logic             bus_is_32bit,
  output logic             internal_reset_n
);

  // power-on counter stands in for the internal power-on reset
  logic [4:0]     por_cnt_ff;
  logic [4:0]     nxt_por_cnt;
  logic           por_done;
  logic           ext_rst_active;
  logic           soft_rst;

  // strap capture
  logic           strap_taken_ff;
  logic           strap_ff;
  logic           strap_window;

  // write gate
  gate_state_type gate_ff;
  gate_state_type nxt_gate;
  logic           read_unlocks;
  logic           wake_relocks;
  logic           write_ok;

  // function decode and pin sources
  logic           data_is_eeprom;
  logic           clk_is_eeprom;
  logic           data_mux;
  logic           clk_mux;
  logic           select_allowed;
  logic           pins_live;
  logic           nxt_data_oe_n;
  logic           nxt_select_n;
  logic           nxt_data_in;

  // registered pad and controller outputs
  logic           eeprom_data_in_ff;
  logic           data_pin_ff;
  logic           data_oe_n_ff;
  logic           clk_pin_ff;
  logic           select_n_ff;

  // power-on count stops at its last value
  assign por_done    = (por_cnt_ff == por_count_last);
  assign nxt_por_cnt = por_done ? por_cnt_ff : por_cnt_ff + 5'h01;

  // reset input absent falls back to power-on reset only
  // a loose pin reads high through the pad pull-up, so it never resets
  assign ext_rst_active   = external_reset_present & ~external_reset_n;
  assign soft_rst         = ext_rst_active | ~por_done;
  assign internal_reset_n = ~soft_rst;

  // power-on count runs once after arst_n
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt_ff <= 5'h00;
    end else begin
      por_cnt_ff <= nxt_por_cnt;
    end
  end

  // strap window: first clock with soft reset gone
  assign strap_window = ~soft_rst & ~strap_taken_ff;

  // strap taken flag, cleared by every reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_taken_ff <= 1'b0;
    end else if (soft_rst) begin
      strap_taken_ff <= 1'b0;
    end else if (strap_window) begin
      strap_taken_ff <= 1'b1;
    end
  end

  // strap level caught once in the window
  // the pad is released during reset so the board strap is seen
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_ff <= strap_reset_value;
    end else if (soft_rst) begin
      strap_ff <= strap_reset_value;
    end else if (strap_window) begin
      strap_ff <= eeprom_serial_data_pin_i;
    end
  end

  // strap read back and width decode
  assign bus_width_strap = strap_ff;
  assign bus_is_32bit    = (strap_ff == width_32_level);

  // a read unlocks, a wake relocks
  assign read_unlocks = host_read;
  assign wake_relocks = wake_event;

  // write gate: locked until first read after reset or wake
  // wake wins only while the gate is open
  always_comb begin
    nxt_gate = gate_ff;
    case (gate_ff)
      gate_locked: begin
        if (read_unlocks) begin
          nxt_gate = gate_open;
        end
      end
      gate_open: begin
        if (wake_relocks) begin
          nxt_gate = gate_locked;
        end
      end
      default: begin
        nxt_gate = gate_locked;
      end
    endcase
  end

  // gate state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_ff <= gate_locked;
    end else if (soft_rst) begin
      gate_ff <= gate_locked;
    end else begin
      gate_ff <= nxt_gate;
    end
  end

  // writes need an open gate, a taken strap and no reset in progress
  assign write_ok         = (gate_ff == gate_open) & strap_taken_ff & ~soft_rst;
  assign write_enabled    = write_ok;
  assign host_write_taken = host_write & write_ok;

  // configuration register, eeprom function after reset
  // a dropped write leaves the old functions in place
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff <= cfg_reset_value;
    end else if (soft_rst) begin
      cfg_ff <= cfg_reset_value;
    end else if (host_write_taken) begin
      cfg_ff <= cfg_wdata;
    end
  end

  // function selection for both pins
  assign data_is_eeprom = (cfg_ff.data_fn == data_fn_eeprom);
  assign clk_is_eeprom  = (cfg_ff.clk_fn == clk_fn_eeprom);
  assign select_allowed = data_is_eeprom & clk_is_eeprom;

  // data pin source; general role is output only
  pin_fn_select data_select (
    .sel     (cfg_ff.data_fn),
    .sources ({tx_clk, tx_en, cfg_ff.general_three, eeprom_data_out}),
    .picked  (data_mux)
  );

  // clock pin source
  pin_fn_select clk_select (
    .sel     (cfg_ff.clk_fn),
    .sources ({rx_clk, rx_dv, cfg_ff.general_four, eeprom_clock}),
    .picked  (clk_mux)
  );

  // pins go live once reset and the strap cycle are over
  // holding the data pad released until then keeps the strap clean
  assign pins_live = ~soft_rst & strap_taken_ff;

  // next values for the pad drivers
  assign nxt_data_oe_n = data_is_eeprom ? ~eeprom_data_drive : 1'b0;
  assign nxt_select_n  = ~(eeprom_select & select_allowed);
  assign nxt_data_in   = data_is_eeprom ? eeprom_serial_data_pin_i : 1'b0;

  // data pin value
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_pin_ff <= 1'b0;
    end else if (!pins_live) begin
      data_pin_ff <= 1'b0;
    end else begin
      data_pin_ff <= data_mux;
    end
  end

  // data pin enable, released in reset for the strap
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_oe_n_ff <= 1'b1;
    end else if (!pins_live) begin
      data_oe_n_ff <= 1'b1;
    end else begin
      data_oe_n_ff <= nxt_data_oe_n;
    end
  end

  // clock pin value
  // mirrored signals pass through one register stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_pin_ff <= 1'b0;
    end else if (!pins_live) begin
      clk_pin_ff <= 1'b0;
    end else begin
      clk_pin_ff <= clk_mux;
    end
  end

  // chip select, inactive in reset
  // select waits for both pins in eeprom mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      select_n_ff <= 1'b1;
    end else if (!pins_live) begin
      select_n_ff <= 1'b1;
    end else begin
      select_n_ff <= nxt_select_n;
    end
  end

  // data read back to the eeprom controller
  // other modes read back zero, no general input
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      eeprom_data_in_ff <= 1'b0;
    end else if (!pins_live) begin
      eeprom_data_in_ff <= 1'b0;
    end else begin
      eeprom_data_in_ff <= nxt_data_in;
    end
  end

  // pad drivers
  assign eeprom_serial_data_pin_o    = data_pin_ff;
  assign eeprom_serial_data_pin_oe_n = data_oe_n_ff;
  assign eeprom_serial_clock_pin     = clk_pin_ff;
  assign eeprom_select_n             = select_n_ff;

  // controller read-back
  assign eeprom_data_in              = eeprom_data_in_ff;

endmodule : eeprom_pin_mux_strap
`default_nettype wire

// ### test/eeprom_model.sv
// serial eeprom stand-in on the shared data pad, with the board strap resistor
// assumes the design releases the pad while the eeprom answers
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
  input  wire logic eeprom_select_n,
  input  wire logic eeprom_serial_clock_pin,
  input  wire logic eeprom_serial_data_pin_o,
  input  wire logic eeprom_serial_data_pin_oe_n,
  input  wire logic strap_lvl,
  output logic      eeprom_serial_data_pin_i
);
  logic bit_ff = 1'b0;
  // shifts a toggling pattern out while selected
  always @(posedge eeprom_serial_clock_pin) if (!eeprom_select_n) bit_ff <= !bit_ff;
  // pad level: design, else eeprom, else strap pull
  assign eeprom_serial_data_pin_i = !eeprom_serial_data_pin_oe_n ? eeprom_serial_data_pin_o
                                  : (!eeprom_select_n ? bit_ff : strap_lvl);
endmodule : eeprom_model
`default_nettype wire

// ### test/eeprom_pin_mux_sva.sv
// port assertions for the eeprom pin multiplexer
// assumes binding onto every multiplexer instance
`timescale 1ns/1ps
`default_nettype none
module eeprom_pin_mux_sva
  import eeprom_pin_mux_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        internal_reset_n,
  input wire logic        host_write,
  input wire logic        host_write_taken,
  input wire logic        write_enabled,
  input wire logic        wake_event,
  input wire logic        tx_en,
  input wire logic        tx_clk,
  input wire logic        rx_dv,
  input wire logic        rx_clk,
  input wire logic        eeprom_serial_data_pin_o,
  input wire logic        eeprom_serial_data_pin_oe_n,
  input wire logic        eeprom_serial_clock_pin,
  input wire logic        eeprom_select_n,
  input wire logic        bus_width_strap,
  input wire logic        bus_is_32bit,
  input wire pin_cfg_type cfg_wdata,
  input wire pin_cfg_type cfg_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence live_s; internal_reset_n [*2]; endsequence
  sequence taken_s; host_write_taken; endsequence
  gate_check_a: assert property (host_write_taken == (host_write && write_enabled))
    else $error("write taken while locked");
  lock_reset_a: assert property (!internal_reset_n |-> !write_enabled)
    else $error("writes open in reset");
  wake_lock_a: assert property (wake_event && write_enabled |=> !write_enabled)
    else $error("wake did not relock");
  cfg_load_a: assert property (taken_s |=> cfg_ff == $past(cfg_wdata))
    else $error("config not loaded");
  cfg_hold_a: assert property (internal_reset_n && !host_write_taken |=> $stable(cfg_ff))
    else $error("config changed alone");
  select_off_a: assert property (cfg_ff.data_fn != data_fn_eeprom || cfg_ff.clk_fn != clk_fn_eeprom
    |=> eeprom_select_n) else $error("select active off eeprom mode");
  tx_mirror_a: assert property (internal_reset_n && cfg_ff.data_fn == data_fn_tx_clk
    |=> eeprom_serial_data_pin_o == $past(tx_clk) && !eeprom_serial_data_pin_oe_n) else $error("tx mirror");
  rx_mirror_a: assert property (internal_reset_n && cfg_ff.clk_fn == clk_fn_rx_dv
    |=> eeprom_serial_clock_pin == $past(rx_dv)) else $error("rx mirror");
  tx_en_mirror_a: assert property (internal_reset_n && cfg_ff.data_fn == data_fn_tx_en
    |=> eeprom_serial_data_pin_o == $past(tx_en) && !eeprom_serial_data_pin_oe_n) else $error("tx enable mirror");
  rx_clk_mirror_a: assert property (internal_reset_n && cfg_ff.clk_fn == clk_fn_rx_clk
    |=> eeprom_serial_clock_pin == $past(rx_clk)) else $error("rx clock mirror");
  strap_hold_a: assert property (live_s |=> $stable(bus_width_strap))
    else $error("strap moved");
  width_map_a: assert property (bus_is_32bit == (bus_width_strap == width_32_level))
    else $error("bus width wrong");
  reset_pins_a: assert property (!internal_reset_n |=> eeprom_select_n && eeprom_serial_data_pin_oe_n)
    else $error("pins live in reset");
endmodule : eeprom_pin_mux_sva
bind eeprom_pin_mux_strap eeprom_pin_mux_sva chk (.*);
`default_nettype wire

// ### test/tb_eeprom_pin_mux_strap.sv
// self-checking bench for the eeprom pin multiplexer
// assumes the eeprom model on the data pad and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_pin_mux_strap
  import eeprom_pin_mux_pkg::*;
;
  logic sys_clk, arst_n, external_reset_n, external_reset_present, wake_event, host_read, host_write;
  logic eeprom_select, eeprom_clock, eeprom_data_out, eeprom_data_drive, tx_en, tx_clk, rx_dv, rx_clk;
  logic host_write_taken, write_enabled, eeprom_data_in, eeprom_serial_data_pin_o, eeprom_serial_data_pin_oe_n;
  logic eeprom_serial_clock_pin, eeprom_select_n, bus_width_strap, bus_is_32bit, internal_reset_n, strap_lvl;
  pin_cfg_type cfg_wdata, cfg_ff, v;
  wire logic   eeprom_serial_data_pin_i;
  int          failures = 0, checks_done = 0;
  eeprom_pin_mux_strap uut (.*);
  eeprom_model em (.*);
  initial begin sys_clk = 0; forever #25 sys_clk = !sys_clk; end
  // random mii activity to mirror
  always @(posedge sys_clk) #5 {tx_en, tx_clk, rx_dv, rx_clk} = 4'($urandom);
  task automatic step(int n); repeat (n) @(posedge sys_clk); #5; endtask : step
  task automatic chk_bit(logic g, logic e);
    checks_done++;
    if (g !== e) begin failures++; $display("wrong value at %0t: %h vs %h", $time, g, e); end
  endtask : chk_bit
  task automatic chk_cfg(pin_cfg_type g, pin_cfg_type e);
    checks_done++;
    if (g !== e) begin failures++; $display("wrong value at %0t: %h vs %h", $time, g, e); end
  endtask : chk_cfg
  function automatic logic exp_sel(pin_cfg_type c);
    return !(c.data_fn == data_fn_eeprom && c.clk_fn == clk_fn_eeprom && eeprom_select);
  endfunction : exp_sel
  task automatic do_reset(logic s);
    arst_n = 0; strap_lvl = s; step(4); arst_n = 1; step(8);
    chk_bit(internal_reset_n, 1'b0);
    step(12); strap_lvl = !s; step(3);
    chk_bit(bus_width_strap, s);
    chk_bit(bus_is_32bit, s == width_32_level);
    chk_cfg(cfg_ff, cfg_reset_value);
  endtask : do_reset
  task automatic rd(); host_read = 1; step(1); host_read = 0; endtask : rd
  task automatic wr(pin_cfg_type w, logic ok);
    pin_cfg_type old;
    old = cfg_ff; cfg_wdata = w; host_write = 1; #1;
    chk_bit(host_write_taken, ok);
    step(1); host_write = 0; step(1);
    chk_cfg(cfg_ff, ok ? w : old);
  endtask : wr
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // watchdog, far beyond the roughly 130 cycles of the tests
  initial begin #2000000; failures++; wrap_up(); end
  initial begin
    {arst_n, external_reset_present, wake_event, host_read, host_write, eeprom_select, eeprom_clock} = '0;
    {eeprom_data_out, eeprom_data_drive, tx_en, tx_clk, rx_dv, rx_clk, strap_lvl} = '0;
    external_reset_n = 1; // pull-up holds the loose pin high
    cfg_wdata = cfg_reset_value;
    void'($urandom(74));
    do_reset(1); do_reset(0);
    wr(pin_cfg_type'(6'($urandom)), 0);
    rd();
    eeprom_select = 1;
    for (int i = 0; i < 16; i++) begin
      v = pin_cfg_type'(6'($urandom)); v.data_fn = data_fn_type'(i[1:0]); v.clk_fn = clk_fn_type'(i[3:2]);
      wr(v, 1);
      chk_bit(eeprom_select_n, exp_sel(v));
      if (v.data_fn == data_fn_general) chk_bit(eeprom_serial_data_pin_o, v.general_three);
      if (v.clk_fn == clk_fn_general) chk_bit(eeprom_serial_clock_pin, v.general_four);
      if (v.data_fn != data_fn_eeprom) chk_bit(eeprom_data_in, 1'b0);
    end
    wr(cfg_reset_value, 1);
    repeat (2) begin
      eeprom_clock = !eeprom_clock; step(3);
      chk_bit(eeprom_serial_data_pin_oe_n, 1'b1);
      chk_bit(eeprom_data_in, eeprom_serial_data_pin_i);
    end
    eeprom_data_drive = 1; eeprom_data_out = !eeprom_serial_data_pin_i; step(3);
    chk_bit(eeprom_serial_data_pin_o, eeprom_data_out);
    chk_bit(eeprom_serial_data_pin_oe_n, 1'b0);
    eeprom_data_drive = 0; wake_event = 1; step(1); wake_event = 0;
    wr(pin_cfg_type'(6'($urandom)), 0);
    rd();
    wr(v, 1);
    external_reset_present = 1; external_reset_n = 0; step(1);
    chk_bit(internal_reset_n, 1'b0);
    chk_cfg(cfg_ff, cfg_reset_value);
    chk_bit(eeprom_select_n, 1'b1);
    external_reset_n = 1; step(20);
    wr(v, 0);
    wrap_up();
  end
endmodule : tb_eeprom_pin_mux_strap
`default_nettype wire
